// File: design/papm_pkg.sv
// Package of register map, field layout and pin roles for the pin mux
package papm_pkg;

  // ****************************************
  // Pin group widths
  // ****************************************
  localparam int UD_W = 8;
  localparam int MID_W = 8;
  localparam int HI_W = 6;

  // ****************************************
  // Roles of the upper address pins (bit 16 is index 0)
  // ****************************************
  localparam int HI_RX_IDX = 2;
  localparam int HI_TX_IDX = 3;
  localparam int HI_CLK_IDX = 4;
  localparam int HI_CAP_IDX = 5;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MID_SEL = 8'h04;
  localparam logic [7:0] REG_HI_SEL = 8'h08;
  localparam logic [7:0] REG_UD_PORT = 8'h0c;
  localparam logic [7:0] REG_UD_DIR = 8'h10;
  localparam logic [7:0] REG_MID_PORT = 8'h14;
  localparam logic [7:0] REG_MID_DIR = 8'h18;
  localparam logic [7:0] REG_HI_PORT = 8'h1c;
  localparam logic [7:0] REG_HI_DIR = 8'h20;
  localparam logic [7:0] REG_PIN_LEVEL = 8'h24;
  localparam logic [7:0] REG_FUNC = 8'h28;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_WIDE_POS = 0;
  localparam int LVL_UD_POS = 0;
  localparam int LVL_MID_POS = 8;
  localparam int LVL_HI_POS = 16;
  localparam int FUNC_ADDR_POS = 0;
  localparam int FUNC_PER_POS = 8;
  localparam int FUNC_WIDE_POS = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_WIDE = 1'b0;
  localparam logic [7:0] RST_MID_SEL = 8'h00;
  localparam logic [5:0] RST_HI_SEL = 6'h00;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;

endpackage

// File: design/papm_wb_slave.sv
// Classic Wishbone handshake: one wait state, ack for one cycle
`timescale 1ns/10ps
module papm_wb_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Access strobe towards the register file
  output logic accept
);

  // ****************************************
  // Handshake
  // ****************************************
  // A new cycle is taken only while ack is low, so ack drops after one cycle
  assign accept = clkEn & cyc_i & stb_i & ~ack_o;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
    end else if (clkEn) begin
      ack_o <= accept;
    end
  end

endmodule

// File: design/papm_pin_cell.sv
// One shared pin: registered output with peripheral, bus, port priority
`timescale 1ns/10ps
module papm_pin_cell (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Peripheral function
  input wire logic periphSel,
  input wire logic periphOut,
  // Bus function
  input wire logic busSel,
  input wire logic busOut,
  input wire logic busOe,
  // Port function
  input wire logic portOut,
  input wire logic portOe,
  // Pin drive
  output logic pinOut,
  output logic pinOe
);

  // ****************************************
  // Function priority
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else if (clkEn) begin
      if (periphSel) begin // [RULE_12]
        pinOut <= periphOut;
        pinOe <= 1'b1;
      end else if (busSel) begin // [RULE_12]
        pinOut <= busOut;
        pinOe <= busOe;
      end else begin
        pinOut <= portOut;
        pinOe <= portOe;
      end
    end
  end

endmodule

// File: design/papm_pin_mux.sv
// Top of the shared data, address and peripheral pin multiplexer
`timescale 1ns/10ps

// Contract
// [RULE_01] Upper data pins carry bus only in 16-bit
// [RULE_02] Middle address pins follow middle select bits
// [RULE_03] Address bits 16 to 18 follow select bits
// [RULE_04] Serial transmit enable overrides bit 19 pin
// [RULE_05] Bit 19 address or port when transmit off
// [RULE_06] Bit 20 port needs both clocks off
// [RULE_07] Bit 21 address or port when data off
// [RULE_08] Serial receive always samples its pin
// [RULE_09] First capture input always sees bit 21 pin
// [RULE_10] First timer input always sees bit 21 pin
// [RULE_11] Bit 20 address needs serial clock off
// [RULE_12] Peripheral over address over port output
module papm_pin_mux (
  // Clock, reset and clock enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // External bus side
  input wire logic [7:0] busDataHiOut,
  input wire logic busDataHiOe,
  output logic [7:0] busDataHiIn,
  input wire logic [7:0] addrMid,
  input wire logic [5:0] addrHi,
  // Serial unit
  input wire logic serialTxOe,
  input wire logic serialTxOut,
  input wire logic serialClkOe,
  input wire logic serialClkOut,
  output logic serialClkIn,
  output logic serialRxIn,
  // Simple serial interface
  input wire logic ssiClkOe,
  input wire logic ssiClkOut,
  input wire logic ssiDataOe,
  input wire logic ssiDataOut,
  // Capture and timer inputs
  output logic captureInFirst,
  output logic timerInFirst,
  // Upper data pins
  input wire logic [7:0] udPinIn,
  output logic [7:0] udPinOut,
  output logic [7:0] udPinOe,
  // Middle address pins
  input wire logic [7:0] midPinIn,
  output logic [7:0] midPinOut,
  output logic [7:0] midPinOe,
  // Upper address pins
  input wire logic [5:0] hiPinIn,
  output logic [5:0] hiPinOut,
  output logic [5:0] hiPinOe
);

  // ****************************************
  // Declarations
  // ****************************************
  logic wideReg;
  logic [7:0] midSelReg;
  logic [5:0] hiSelReg;
  logic [7:0] udPortReg;
  logic [7:0] udDirReg;
  logic [7:0] midPortReg;
  logic [7:0] midDirReg;
  logic [5:0] hiPortReg;
  logic [5:0] hiDirReg;
  logic [7:0] udLevelReg;
  logic [7:0] midLevelReg;
  logic [5:0] hiLevelReg;
  logic [5:0] hiPerSel;
  logic [5:0] hiPerOut;
  logic [5:0] hiAddrActive;
  logic accept;
  logic wrEn;
  logic [31:0] rdWord;

  // Byte lane 0 carries every writable field
  function automatic logic [7:0] laneWrite(input logic [7:0] oldVal,
                                           input logic [31:0] data,
                                           input logic [3:0] sel);
    laneWrite = sel[0] ? data[7:0] : oldVal;
  endfunction

  // ****************************************
  // Bus handshake
  // ****************************************
  papm_wb_slave uWb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_o),
    .accept(accept)
  );

  assign wrEn = accept & we_i;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wideReg <= papm_pkg::RST_WIDE;
      midSelReg <= papm_pkg::RST_MID_SEL;
      hiSelReg <= papm_pkg::RST_HI_SEL;
    end else if (wrEn) begin
      if (adr_i == papm_pkg::REG_CTRL) begin
        wideReg <= dat_i[papm_pkg::CTRL_WIDE_POS] & sel_i[0] |
                   wideReg & ~sel_i[0];
      end else if (adr_i == papm_pkg::REG_MID_SEL) begin
        midSelReg <= laneWrite(midSelReg, dat_i, sel_i);
      end else if (adr_i == papm_pkg::REG_HI_SEL) begin
        hiSelReg <= 6'(laneWrite({2'b00, hiSelReg}, dat_i, sel_i));
      end
    end
  end

  // ****************************************
  // Port data and direction registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      udPortReg <= papm_pkg::RST_PORT;
      udDirReg <= papm_pkg::RST_DIR;
      midPortReg <= papm_pkg::RST_PORT;
      midDirReg <= papm_pkg::RST_DIR;
      hiPortReg <= papm_pkg::RST_PORT[5:0];
      hiDirReg <= papm_pkg::RST_DIR[5:0];
    end else if (wrEn) begin
      if (adr_i == papm_pkg::REG_UD_PORT) begin
        udPortReg <= laneWrite(udPortReg, dat_i, sel_i);
      end else if (adr_i == papm_pkg::REG_UD_DIR) begin
        udDirReg <= laneWrite(udDirReg, dat_i, sel_i);
      end else if (adr_i == papm_pkg::REG_MID_PORT) begin
        midPortReg <= laneWrite(midPortReg, dat_i, sel_i);
      end else if (adr_i == papm_pkg::REG_MID_DIR) begin
        midDirReg <= laneWrite(midDirReg, dat_i, sel_i);
      end else if (adr_i == papm_pkg::REG_HI_PORT) begin
        hiPortReg <= 6'(laneWrite({2'b00, hiPortReg}, dat_i, sel_i));
      end else if (adr_i == papm_pkg::REG_HI_DIR) begin
        hiDirReg <= 6'(laneWrite({2'b00, hiDirReg}, dat_i, sel_i));
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rdWord = 32'h0000_0000;
    if (adr_i == papm_pkg::REG_CTRL) begin
      rdWord = 32'(wideReg) << papm_pkg::CTRL_WIDE_POS;
    end else if (adr_i == papm_pkg::REG_MID_SEL) begin
      rdWord = 32'(midSelReg);
    end else if (adr_i == papm_pkg::REG_HI_SEL) begin
      rdWord = 32'(hiSelReg);
    end else if (adr_i == papm_pkg::REG_UD_PORT) begin
      rdWord = 32'(udPortReg);
    end else if (adr_i == papm_pkg::REG_UD_DIR) begin
      rdWord = 32'(udDirReg);
    end else if (adr_i == papm_pkg::REG_MID_PORT) begin
      rdWord = 32'(midPortReg);
    end else if (adr_i == papm_pkg::REG_MID_DIR) begin
      rdWord = 32'(midDirReg);
    end else if (adr_i == papm_pkg::REG_HI_PORT) begin
      rdWord = 32'(hiPortReg);
    end else if (adr_i == papm_pkg::REG_HI_DIR) begin
      rdWord = 32'(hiDirReg);
    end else if (adr_i == papm_pkg::REG_PIN_LEVEL) begin
      rdWord = (32'(udLevelReg) << papm_pkg::LVL_UD_POS) |
               (32'(midLevelReg) << papm_pkg::LVL_MID_POS) |
               (32'(hiLevelReg) << papm_pkg::LVL_HI_POS);
    end else if (adr_i == papm_pkg::REG_FUNC) begin
      rdWord = (32'(hiAddrActive) << papm_pkg::FUNC_ADDR_POS) |
               (32'(hiPerSel) << papm_pkg::FUNC_PER_POS) |
               (32'(wideReg) << papm_pkg::FUNC_WIDE_POS);
    end
  end

  // Unmapped offsets answer with zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_o <= 32'h0000_0000;
    end else if (accept && !we_i) begin
      dat_o <= rdWord;
    end
  end

  // ****************************************
  // Peripheral selection on the upper address pins
  // ****************************************
  always_comb begin
    hiPerSel = 6'h00;
    hiPerOut = 6'h00;
    hiPerSel[papm_pkg::HI_TX_IDX] = serialTxOe; // [RULE_04]
    hiPerOut[papm_pkg::HI_TX_IDX] = serialTxOut;
    // Serial clock wins over the simple serial clock when both drive
    hiPerSel[papm_pkg::HI_CLK_IDX] = serialClkOe | ssiClkOe; // [RULE_06]
    hiPerOut[papm_pkg::HI_CLK_IDX] = serialClkOe ? serialClkOut : ssiClkOut;
    hiPerSel[papm_pkg::HI_CAP_IDX] = ssiDataOe; // [RULE_07]
    hiPerOut[papm_pkg::HI_CAP_IDX] = ssiDataOut;
  end

  assign hiAddrActive = hiSelReg & ~hiPerSel; // [RULE_12]

  // ****************************************
  // Pin cells
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < papm_pkg::UD_W; gi++) begin : gUd
      papm_pin_cell uCell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .periphSel(1'b0),
        .periphOut(1'b0),
        .busSel(wideReg), // [RULE_01]
        .busOut(busDataHiOut[gi]),
        .busOe(busDataHiOe),
        .portOut(udPortReg[gi]),
        .portOe(udDirReg[gi]),
        .pinOut(udPinOut[gi]),
        .pinOe(udPinOe[gi])
      );
    end
    for (gi = 0; gi < papm_pkg::MID_W; gi++) begin : gMid
      papm_pin_cell uCell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .periphSel(1'b0),
        .periphOut(1'b0),
        .busSel(midSelReg[gi]), // [RULE_02]
        .busOut(addrMid[gi]),
        .busOe(1'b1),
        .portOut(midPortReg[gi]),
        .portOe(midDirReg[gi]),
        .pinOut(midPinOut[gi]),
        .pinOe(midPinOe[gi])
      );
    end
    for (gi = 0; gi < papm_pkg::HI_W; gi++) begin : gHi
      papm_pin_cell uCell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .periphSel(hiPerSel[gi]), // [RULE_05]
        .periphOut(hiPerOut[gi]),
        .busSel(hiSelReg[gi]), // [RULE_03] [RULE_11]
        .busOut(addrHi[gi]),
        .busOe(1'b1),
        .portOut(hiPortReg[gi]),
        .portOe(hiDirReg[gi]),
        .pinOut(hiPinOut[gi]),
        .pinOe(hiPinOe[gi])
      );
    end
  endgenerate

  // ****************************************
  // Inputs that stay connected to their pins
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serialRxIn <= 1'b0;
      serialClkIn <= 1'b0;
      captureInFirst <= 1'b0;
      timerInFirst <= 1'b0;
      busDataHiIn <= 8'h00;
    end else if (clkEn) begin
      serialRxIn <= hiPinIn[papm_pkg::HI_RX_IDX]; // [RULE_08]
      serialClkIn <= hiPinIn[papm_pkg::HI_CLK_IDX];
      captureInFirst <= hiPinIn[papm_pkg::HI_CAP_IDX]; // [RULE_09]
      timerInFirst <= hiPinIn[papm_pkg::HI_CAP_IDX]; // [RULE_10]
      busDataHiIn <= udPinIn;
    end
  end

  // Pin levels for software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      udLevelReg <= 8'h00;
      midLevelReg <= 8'h00;
      hiLevelReg <= 6'h00;
    end else if (clkEn) begin
      udLevelReg <= udPinIn;
      midLevelReg <= midPinIn;
      hiLevelReg <= hiPinIn;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_UD_BUS_WIDE: assert property ( // [RULE_01]
    clkEn && wideReg |=> udPinOut == $past(busDataHiOut) &&
      udPinOe == {8{$past(busDataHiOe)}})
    else $error("upper data pins not on bus in wide mode");

  AST_UD_PORT_NARROW: assert property ( // [RULE_01]
    clkEn && !wideReg |=> udPinOut == $past(udPortReg) &&
      udPinOe == $past(udDirReg))
    else $error("upper data pins not on port in narrow mode");

  AST_MID_SELECT: assert property ( // [RULE_02]
    clkEn |=> midPinOut == (($past(midSelReg) & $past(addrMid)) |
      (~$past(midSelReg) & $past(midPortReg))))
    else $error("middle address pin function wrong");

  AST_HI_LOW_ADDR: assert property ( // [RULE_03]
    clkEn && hiSelReg[0] && hiSelReg[2] |=>
      hiPinOut[0] == $past(addrHi[0]) && hiPinOe[0] && hiPinOe[2] &&
      hiPinOut[2] == $past(addrHi[2]))
    else $error("address bit 16 or 18 not driven");

  AST_TX_OVERRIDE: assert property ( // [RULE_04]
    clkEn && serialTxOe |=> hiPinOe[3] &&
      hiPinOut[3] == $past(serialTxOut))
    else $error("serial transmit not on shared pin");

  AST_TX_OFF_PORT: assert property ( // [RULE_05]
    clkEn && !serialTxOe && !hiSelReg[3] |=>
      hiPinOut[3] == $past(hiPortReg[3]) && hiPinOe[3] == $past(hiDirReg[3]))
    else $error("bit 19 pin not on port");

  AST_CLK_PORT: assert property ( // [RULE_06]
    clkEn && !serialClkOe && !ssiClkOe && !hiSelReg[4] |=>
      hiPinOe[4] == $past(hiDirReg[4]) && hiPinOut[4] == $past(hiPortReg[4]))
    else $error("bit 20 pin not on port");

  AST_DATA_OFF_ADDR: assert property ( // [RULE_07]
    clkEn && !ssiDataOe && hiSelReg[5] |=>
      hiPinOe[5] && hiPinOut[5] == $past(addrHi[5]))
    else $error("bit 21 pin not on address");

  AST_RX_FOLLOWS: assert property ( // [RULE_08]
    clkEn |=> serialRxIn == $past(hiPinIn[2]))
    else $error("serial receive lost its pin");

  AST_CAPTURE_FOLLOWS: assert property ( // [RULE_09]
    clkEn |=> captureInFirst == $past(hiPinIn[5]))
    else $error("capture input lost its pin");

  AST_TIMER_FOLLOWS: assert property ( // [RULE_10]
    clkEn |=> timerInFirst == $past(hiPinIn[5]) &&
      timerInFirst == captureInFirst)
    else $error("timer input lost its pin");

  AST_CLK_ADDR: assert property ( // [RULE_11]
    clkEn && !serialClkOe && !ssiClkOe && hiSelReg[4] |=>
      hiPinOe[4] && hiPinOut[4] == $past(addrHi[4]))
    else $error("bit 20 pin not on address");

  AST_SERIAL_CLK_FIRST: assert property ( // [RULE_12]
    clkEn && serialClkOe && ssiClkOe |=>
      hiPinOe[4] && hiPinOut[4] == $past(serialClkOut))
    else $error("serial clock lost priority");

  AST_FROZEN: assert property (
    !clkEn |=> $stable(hiPinOut) && $stable(hiPinOe) && $stable(midPinOut))
    else $error("pins changed with clock enable low");

  AST_ACK_ONE: assert property (
    clkEn && cyc_i && stb_i && !ack_o |=> ack_o ##1 (!ack_o || !clkEn))
    else $error("bus answer not single cycle");

  COV_WIDE_MODE: cover property (clkEn && wideReg ##1 udPinOe != 8'h00);
  COV_TX_OVERRIDE: cover property (serialTxOe && hiSelReg[3] ##1 hiPinOe[3]);
  COV_SSI_CLOCK: cover property (ssiClkOe && !serialClkOe && clkEn);
  COV_READ: cover property (accept && !we_i ##1 ack_o);

endmodule

// File: test/papm_pad_model.sv
// Pad and far-side model: resolves pin levels from all drivers
`timescale 1ns/10ps
module papm_pad_model #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Design drive
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe,
  // External device drive
  input wire logic [W-1:0] extOe,
  input wire logic [W-1:0] extVal,
  // Resolved level
  output logic [W-1:0] pinIn
);
  // ****************************************
  // Floating lines
  // ****************************************
  logic [W-1:0] floatReg;

  // Undriven lines toggle so a stale value is never read as valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      floatReg <= '0;
    end else begin
      floatReg <= ~floatReg;
    end
  end

  // Design drive first, then the external device, else floating
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : (extOe[i] ? extVal[i] : floatReg[i]);
    end
  end

endmodule

// File: test/papm_pin_mux_tb_top.sv
// Testbench of the shared pin multiplexer
`timescale 1ns/10ps
module papm_pin_mux_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] datW = 32'h0;
  logic [31:0] datR;
  logic ack;
  logic [7:0] busHiOut = 8'h00;
  logic busHiOe = 1'b0;
  logic [7:0] busHiIn;
  logic [7:0] addrMid = 8'h00;
  logic [5:0] addrHi = 6'h00;
  logic txOe = 1'b0, txOut = 1'b0, sClkOe = 1'b0, sClkOut = 1'b0;
  logic ssClkOe = 1'b0, ssClkOut = 1'b0, ssDatOe = 1'b0, ssDatOut = 1'b0;
  logic sClkIn, rxIn, capIn, tmrIn;
  logic [7:0] udIn, udOut, udOe, midIn, midOut, midOe;
  logic [5:0] hiIn, hiOut, hiOe;
  logic [5:0] hiExtOe = 6'h00;
  logic [5:0] hiExtVal = 6'h00;
  logic [7:0] udExtOe = 8'h00;
  logic [7:0] udExtVal = 8'h00;
  logic [7:0] midExtOe = 8'h00;
  logic [7:0] midExtVal = 8'h00;
  logic [3:0] selW = 4'hf;
  logic [31:0] rd;
  int failCount = 0;
  int nTests = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  // ****************************************
  // Design and pads
  // ****************************************
  papm_pin_mux dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(datW), .dat_o(datR), .ack_o(ack), .busDataHiOut(busHiOut),
    .busDataHiOe(busHiOe), .busDataHiIn(busHiIn), .addrMid(addrMid),
    .addrHi(addrHi), .serialTxOe(txOe), .serialTxOut(txOut),
    .serialClkOe(sClkOe), .serialClkOut(sClkOut), .serialClkIn(sClkIn),
    .serialRxIn(rxIn), .ssiClkOe(ssClkOe), .ssiClkOut(ssClkOut),
    .ssiDataOe(ssDatOe), .ssiDataOut(ssDatOut), .captureInFirst(capIn),
    .timerInFirst(tmrIn), .udPinIn(udIn), .udPinOut(udOut), .udPinOe(udOe),
    .midPinIn(midIn), .midPinOut(midOut), .midPinOe(midOe),
    .hiPinIn(hiIn), .hiPinOut(hiOut), .hiPinOe(hiOe));
  papm_pad_model #(.W(8)) padUd (.clk_sys(clk_sys), .rst_n(rst_n),
    .pinOut(udOut), .pinOe(udOe), .extOe(udExtOe), .extVal(udExtVal),
    .pinIn(udIn));
  papm_pad_model #(.W(8)) padMid (.clk_sys(clk_sys), .rst_n(rst_n),
    .pinOut(midOut), .pinOe(midOe), .extOe(midExtOe), .extVal(midExtVal),
    .pinIn(midIn));
  papm_pad_model #(.W(6)) padHi (.clk_sys(clk_sys), .rst_n(rst_n),
    .pinOut(hiOut), .pinOe(hiOe), .extOe(hiExtOe), .extVal(hiExtVal),
    .pinIn(hiIn));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
    // Next stimulus starts on a rising edge
    @(posedge clk_sys);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= selW;
    datW <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    chk({10'h0, udOe, midOe, hiOe}, 32'h0);
    rst_n <= 1'b1;
    wb(1'b0, papm_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, papm_pkg::REG_HI_SEL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    // Upper data: port in narrow mode, bus in wide mode
    wb(1'b1, papm_pkg::REG_UD_PORT, 32'ha5);
    wb(1'b1, papm_pkg::REG_UD_DIR, 32'hff);
    busHiOut <= 8'h3c;
    busHiOe <= 1'b1;
    settle();
    chk({udOe, udOut}, 32'hffa5);
    wb(1'b1, papm_pkg::REG_CTRL, 32'h1);
    settle();
    chk({udOe, udOut}, 32'hff3c);
    wb(1'b0, papm_pkg::REG_FUNC, 32'h0);
    chk(rd & 32'h1_0000, 32'h1_0000);
    // Middle address byte chosen bit by bit
    addrMid <= 8'h5a;
    wb(1'b1, papm_pkg::REG_MID_SEL, 32'h0f);
    wb(1'b1, papm_pkg::REG_MID_PORT, 32'hf0);
    wb(1'b1, papm_pkg::REG_MID_DIR, 32'h30);
    settle();
    chk({midOe, midOut}, 32'h3ffa);
    // A write without byte lane 0 leaves the select bits alone
    selW = 4'he;
    wb(1'b1, papm_pkg::REG_MID_SEL, 32'hff);
    selW = 4'hf;
    wb(1'b0, papm_pkg::REG_MID_SEL, 32'h0);
    chk(rd, 32'h0f);
    // Upper address: all address, then each peripheral takes its pin
    addrHi <= 6'h3f;
    wb(1'b1, papm_pkg::REG_HI_SEL, 32'h3f);
    settle();
    chk({hiOe, hiOut}, 32'hfff);
    txOe <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'hff7);
    txOe <= 1'b0;
    sClkOe <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'hfef);
    sClkOe <= 1'b0;
    ssClkOe <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'hfef);
    sClkOe <= 1'b1;
    sClkOut <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'hfff);
    sClkOe <= 1'b0;
    ssClkOe <= 1'b0;
    ssDatOe <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'hfdf);
    // Port mode with all peripherals off, then the simple serial clock takes bit 20
    ssDatOe <= 1'b0;
    wb(1'b1, papm_pkg::REG_HI_SEL, 32'h00);
    wb(1'b1, papm_pkg::REG_HI_PORT, 32'h2a);
    wb(1'b1, papm_pkg::REG_HI_DIR, 32'h3f);
    settle();
    chk({hiOe, hiOut}, 32'hfea);
    ssClkOe <= 1'b1;
    ssClkOut <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'hffa);
    ssClkOe <= 1'b0;
    // Peripheral inputs watch their pins while the design does not drive
    wb(1'b1, papm_pkg::REG_HI_DIR, 32'h00);
    hiExtOe <= 6'h34;
    hiExtVal <= 6'h24;
    settle();
    chk({rxIn, sClkIn, capIn, tmrIn}, 32'hb);
    hiExtVal <= 6'h10;
    settle();
    chk({rxIn, sClkIn, capIn, tmrIn}, 32'h4);
    // Capture and timer still see the pin while address drives it
    hiExtOe <= 6'h14;
    wb(1'b1, papm_pkg::REG_HI_SEL, 32'h20);
    settle();
    chk({hiOe[5], capIn, tmrIn}, 32'h7);
    // Clock enable low holds every upper address pin
    clkEn <= 1'b0;
    txOe <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'h82a);
    clkEn <= 1'b1;
    settle();
    chk({hiOe, hiOut}, 32'ha22);
    txOe <= 1'b0;
    // Upper data and middle pins read back from the far side
    wb(1'b1, papm_pkg::REG_CTRL, 32'h0);
    wb(1'b1, papm_pkg::REG_UD_DIR, 32'h0);
    wb(1'b1, papm_pkg::REG_MID_SEL, 32'h0);
    wb(1'b1, papm_pkg::REG_MID_DIR, 32'h0);
    udExtOe <= 8'hff;
    udExtVal <= 8'h69;
    midExtOe <= 8'hff;
    midExtVal <= 8'h96;
    settle();
    chk(32'(busHiIn), 32'h69);
    wb(1'b0, papm_pkg::REG_PIN_LEVEL, 32'h0);
    chk(rd & 32'h34_ffff, 32'h30_9669);
    wb(1'b0, papm_pkg::REG_FUNC, 32'h0);
    chk(rd, 32'h20);
    tally_and_finish();
  end

endmodule
